// ### logic/wide_counter_pkg.sv
// Purpose: Shared constants and types for the wide event counter
// Assumes: APB with 32-bit data, byte registers in low bits
// Notes: Offsets are printed register numbers used as word indices
`default_nettype none
package wide_counter_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INTCTL = 8'h0B;
    localparam logic [7:0] IDX_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_CNT_LO = 8'h0E;
    localparam logic [7:0] IDX_CNT_HI = 8'h0F;
    localparam logic [7:0] IDX_CTRL = 8'h10;
    localparam logic [7:0] IDX_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_CMP_LO = 8'h15;
    localparam logic [7:0] IDX_CMP_HI = 8'h16;
    localparam logic [7:0] IDX_CMP_MODE = 8'h17;
    // Control field positions
    localparam int CTRL_ON = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_BYPASS = 2;
    localparam int CTRL_OSC = 3;
    localparam int CTRL_PS_LO = 4;
    localparam int CTRL_PS_HI = 5;
    localparam logic [7:0] CTRL_MASK = 8'h3F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int FLAG_OVF = 0;
    localparam logic [7:0] FLAGS_MASK = 8'hF7;
    localparam logic [7:0] ENABLES_MASK = 8'hF7;
    localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hB;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam int CPU_CLK_MHZ = 40;

    // Control register fields as a packed carrier
    typedef struct packed {
        logic [1:0] spare;
        logic [1:0] prescale_select;
        logic crystal_osc_enable;
        logic sync_bypass;
        logic clock_source_select;
        logic counter_on;
    } ctrl_t;

    // APB access phase summary
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [7:0] wdata;
    } access_t;
endpackage
`default_nettype wire

// ### logic/input_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes: Output changes once stages two and three agree
`default_nettype none
`timescale 1ns/100ps
module input_sync
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic async_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else if (ce_i)
        begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a change only when the later stages agree
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            level_o <= 1'b0;
        else if (ce_i && s2 == s3)
            level_o <= s3;
    end
endmodule
`default_nettype wire

// ### logic/ripple_prescaler.sv
// Purpose: Prescaler for the count input, divide by 1, 2, 4 or 8
// Assumes: tick_i is a one-cycle pulse
// Notes: Clear has priority over a tick in the same cycle
`default_nettype none
`timescale 1ns/100ps
module ripple_prescaler
#(
    parameter int WIDTH = 3
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [1:0] select_i,
    output logic tick_o
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] mask;

    // Terminal mask for the selected ratio
    always_comb
    begin
        mask = WIDTH'((1 << select_i) - 1);
        next_count = count + WIDTH'(1);
        tick_o = tick_i && ((count & mask) == mask);
    end

    // Counter keeps running in sleep; besides reset, only a count write clears it
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            count <= '0;
        else if (ce_i)
        begin
            if (clear_i)
                count <= '0;
            else if (tick_i)
                count <= next_count;
        end
    end
endmodule
`default_nettype wire

// ### logic/wide_event_counter.sv
// Purpose: 16-bit timer/counter with prescaler and compare clear
// Assumes: APB slave, 32-bit data, one word per byte register
// Notes: Count bytes have no reset; only compare clear, a software byte write or rollover past FFFF zeroes them
//
// The APB slave port was left to the implementer.
`default_nettype none
`timescale 1ns/100ps
// What this block does
// - Bypass set: external edges still pass the synchroniser
// - Unsynchronised mode counts in sleep, wakes on overflow
// - Unsynchronised mode gives compare unit no timebase
// - Byte reads always valid; overflow may straddle
// - Oscillator enable runs crystal, also in sleep
// - Compare mode 1011 trigger clears counter
// - Compare clear never sets overflow flag
// - Compare clear withheld in unsynchronised mode
// - Software count write beats compare clear
// - Compare value pair acts as period
// - Count bytes unaffected by any reset
// - Power-on or brown-out clears control register
// - Any count byte write clears prescaler
// - Count exposed as low and high bytes
// - Source clear counts oscillator divided by four
// - Prescale codes divide by 1, 2, 4, 8
// - Synchronised mode: no count in sleep
module wide_event_counter
#(
    parameter int PS_WIDTH = 3
)
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic POR_BOR_I,
    input wire logic SLEEP_I,
    input wire logic EXT_CLK_I,
    input wire logic CRYSTAL_INPUT_PIN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic CRYSTAL_AMP_OUTPUT_PIN_O,
    output logic CRYSTAL_AMP_OE_B_O,
    output logic TIMEBASE_VALID_O,
    output logic WAKE_O,
    output logic IRQ_O
);
    wide_counter_pkg::ctrl_t ctrl;
    wide_counter_pkg::access_t acc;
    logic [15:0] count_value;
    logic [15:0] next_count_value;
    logic [15:0] compare_value_pair;
    logic [3:0] compare_mode_select;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] intctl;
    logic [1:0] instr_div;
    logic instr_tick;
    logic ext_level;
    logic ext_prev;
    logic ext_rise;
    logic src_tick;
    logic ps_tick;
    logic cnt_wr;
    logic inc;
    logic match;
    logic special_clear;
    logic overflow;
    logic unsync_mode;
    logic addr_ok;
    logic [31:0] rdata;

    // Decode of the APB access phase; word index from the byte address
    always_comb
    begin
        acc.idx = PADDR_I[9:2];
        acc.wdata = PWDATA_I[7:0];
        acc.wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
        acc.rd = PSEL_I && PENABLE_I && !PWRITE_I && PREADY_O;
        addr_ok = (PADDR_I[1:0] == 2'h0) && (PADDR_I[31:10] == '0);
    end

    // Pin source: crystal pin when oscillator runs, else plain clock pin
    input_sync ext_sync
    (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .ce_i(CE_I),
        .async_i(ctrl.crystal_osc_enable ? CRYSTAL_INPUT_PIN_I : EXT_CLK_I),
        .level_o(ext_level)
    );

    // Instruction clock is one cycle in four of the core clock
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            instr_div <= 2'h0;
        else if (CE_I && !SLEEP_I)
            instr_div <= instr_div + 2'h1;
    end

    // Rising-edge detect on the filtered level, never on a raw stage
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            ext_prev <= 1'b0;
        else if (CE_I)
            ext_prev <= ext_level;
    end

    // Count source and mode selection
    always_comb
    begin
        instr_tick = !SLEEP_I && (instr_div == wide_counter_pkg::INSTR_DIV_LAST);
        ext_rise = ext_level && !ext_prev;
        unsync_mode = ctrl.clock_source_select && ctrl.sync_bypass;
        if (ctrl.clock_source_select)
            src_tick = ext_rise;
        else
            src_tick = instr_tick;
    end

    // Prescaler sits after the sync stage and has no sleep input, so external edges advance it in sleep
    ripple_prescaler #(.WIDTH(PS_WIDTH)) prescale
    (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .ce_i(CE_I),
        .clear_i(cnt_wr),
        .tick_i(src_tick && ctrl.counter_on),
        .select_i(ctrl.prescale_select),
        .tick_o(ps_tick)
    );

    // Counter advance and compare-triggered clear
    always_comb
    begin
        cnt_wr = acc.wr && (acc.idx == wide_counter_pkg::IDX_CNT_LO ||
                            acc.idx == wide_counter_pkg::IDX_CNT_HI);
        // Synchronised mode stalls in sleep; unsynchronised keeps going
        inc = ps_tick && (unsync_mode || !SLEEP_I);
        match = (count_value == compare_value_pair);
        // Clear is withheld in unsynchronised mode, the unsafe case
        special_clear = match && !unsync_mode &&
            (compare_mode_select == wide_counter_pkg::CMP_SPECIAL_EVENT);
        overflow = inc && (count_value == 16'hFFFF) && !special_clear;
        next_count_value = count_value + 16'h0001;
    end

    // Count bytes carry no reset, by design of the register pair
    always_ff @(posedge CLK_I)
    begin
        if (CE_I)
        begin
            if (acc.wr && acc.idx == wide_counter_pkg::IDX_CNT_LO)
                count_value[7:0] <= acc.wdata;
            else if (acc.wr && acc.idx == wide_counter_pkg::IDX_CNT_HI)
                count_value[15:8] <= acc.wdata;
            else if (special_clear)
                count_value <= 16'h0000;
            else if (inc)
                count_value <= next_count_value;
        end
    end

    // Control register: only power-on or brown-out resets it, so it has
    // no asynchronous reset; any other reset leaves it as it was
    always_ff @(posedge CLK_I)
    begin
        if (CE_I)
        begin
            if (POR_BOR_I)
                ctrl <= wide_counter_pkg::CTRL_RESET;
            else if (acc.wr && acc.idx == wide_counter_pkg::IDX_CTRL)
                ctrl <= acc.wdata & wide_counter_pkg::CTRL_MASK;
        end
    end

    // Compare unit settings seen by this block
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            compare_value_pair <= 16'h0000;
            compare_mode_select <= 4'h0;
        end
        else if (CE_I && acc.wr)
        begin
            if (acc.idx == wide_counter_pkg::IDX_CMP_LO)
                compare_value_pair[7:0] <= acc.wdata;
            if (acc.idx == wide_counter_pkg::IDX_CMP_HI)
                compare_value_pair[15:8] <= acc.wdata;
            if (acc.idx == wide_counter_pkg::IDX_CMP_MODE)
                compare_mode_select <= acc.wdata[3:0];
        end
    end

    // Overflow flag: hardware set wins over a software clear
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            flags <= 8'h00;
        else if (CE_I)
        begin
            if (acc.wr && acc.idx == wide_counter_pkg::IDX_FLAGS)
                flags <= acc.wdata & wide_counter_pkg::FLAGS_MASK;
            if (overflow)
                flags[wide_counter_pkg::FLAG_OVF] <= 1'b1;
        end
    end

    // Enables and main interrupt control are plain storage
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            enables <= 8'h00;
            intctl <= 8'h00;
        end
        else if (CE_I && acc.wr)
        begin
            if (acc.idx == wide_counter_pkg::IDX_ENABLES)
                enables <= acc.wdata & wide_counter_pkg::ENABLES_MASK;
            if (acc.idx == wide_counter_pkg::IDX_INTCTL)
                intctl <= acc.wdata;
        end
    end

    // Read mux; count bytes are sampled in the core domain, so valid
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (acc.idx)
            wide_counter_pkg::IDX_INTCTL: rdata[7:0] = intctl;
            wide_counter_pkg::IDX_FLAGS: rdata[7:0] = flags;
            wide_counter_pkg::IDX_CNT_LO: rdata[7:0] = count_value[7:0];
            wide_counter_pkg::IDX_CNT_HI: rdata[7:0] = count_value[15:8];
            wide_counter_pkg::IDX_CTRL: rdata[7:0] = ctrl;
            wide_counter_pkg::IDX_ENABLES: rdata[7:0] = enables;
            wide_counter_pkg::IDX_CMP_LO: rdata[7:0] = compare_value_pair[7:0];
            wide_counter_pkg::IDX_CMP_HI: rdata[7:0] = compare_value_pair[15:8];
            wide_counter_pkg::IDX_CMP_MODE: rdata[3:0] = compare_mode_select;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // APB answer: ready one cycle after setup, data registered
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else if (CE_I)
        begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PRDATA_O <= rdata;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !addr_ok;
        end
    end

    // Crystal amplifier drives its pin only while enabled, in sleep too
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            CRYSTAL_AMP_OUTPUT_PIN_O <= 1'b0;
            CRYSTAL_AMP_OE_B_O <= 1'b1;
        end
        else if (CE_I)
        begin
            CRYSTAL_AMP_OUTPUT_PIN_O <= !CRYSTAL_INPUT_PIN_I;
            CRYSTAL_AMP_OE_B_O <= !ctrl.crystal_osc_enable;
        end
    end

    // Status outputs: timebase, wake and interrupt request
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            TIMEBASE_VALID_O <= 1'b0;
            WAKE_O <= 1'b0;
            IRQ_O <= 1'b0;
        end
        else if (CE_I)
        begin
            TIMEBASE_VALID_O <= ctrl.counter_on && !unsync_mode;
            WAKE_O <= flags[wide_counter_pkg::FLAG_OVF] &&
                enables[wide_counter_pkg::FLAG_OVF];
            IRQ_O <= flags[wide_counter_pkg::FLAG_OVF] &&
                enables[wide_counter_pkg::FLAG_OVF];
        end
    end
endmodule
`default_nettype wire

// ### tb/wide_event_counter_sva.sv
// Purpose: Port checks for the wide event counter
// Assumes: One clock; APB master holds requests until ready
// Notes: Bound into every counter instance
`timescale 1ns/100ps
`default_nettype none
module wide_event_counter_sva
#(
    parameter int PS_WIDTH = 3
)
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic POR_BOR_I,
    input wire logic CRYSTAL_INPUT_PIN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CRYSTAL_AMP_OUTPUT_PIN_O,
    input wire logic CRYSTAL_AMP_OE_B_O,
    input wire logic TIMEBASE_VALID_O,
    input wire logic WAKE_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // Control write seen at its access edge
    logic ctl_wr;
    assign ctl_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
        && PADDR_I == 32'h40;
    a_ready_one_wait: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("ready missing after setup");
    a_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside access");
    a_ready_single: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    a_err_misaligned: assert property (PSEL_I && !PENABLE_I
        && PADDR_I[1:0] != 2'h0 |=> PSLVERR_O && PREADY_O)
        else $error("misaligned access not refused");
    a_wake_irq_same: assert property (IRQ_O == WAKE_O)
        else $error("wake and irq differ");
    a_osc_enable_drive: assert property (ctl_wr && PWDATA_I[3]
        |-> ##[1:2] !CRYSTAL_AMP_OE_B_O)
        else $error("oscillator pin not driven");
    a_amp_inverts_in: assert property (!CRYSTAL_AMP_OE_B_O
        && !$past(CRYSTAL_AMP_OE_B_O)
        |-> CRYSTAL_AMP_OUTPUT_PIN_O == !$past(CRYSTAL_INPUT_PIN_I))
        else $error("amplifier not inverting");
    a_unsync_no_base: assert property (ctl_wr && PWDATA_I[2:1] == 2'h3
        |-> ##[1:2] !TIMEBASE_VALID_O)
        else $error("timebase offered in unsync mode");
    a_por_stops_all: assert property (POR_BOR_I
        |-> ##[1:2] CRYSTAL_AMP_OE_B_O && !TIMEBASE_VALID_O)
        else $error("power-on reset left control set");
    // Main scenarios reached
    c_refused: cover property (PSLVERR_O);
    c_irq: cover property ($rose(IRQ_O));
    c_osc: cover property ($fell(CRYSTAL_AMP_OE_B_O));
endmodule
bind wide_event_counter wide_event_counter_sva #(.PS_WIDTH(PS_WIDTH)) sva_inst
(
    .CLK_I, .RST_B_I, .POR_BOR_I, .CRYSTAL_INPUT_PIN_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O,
    .CRYSTAL_AMP_OUTPUT_PIN_O, .CRYSTAL_AMP_OE_B_O, .TIMEBASE_VALID_O,
    .WAKE_O, .IRQ_O
);
`default_nettype wire

// ### tb/ext_source.sv
// Purpose: Far-side count source on the external or crystal pin
// Assumes: Steps on core clock rising edges
// Notes: Both pins rest low between bursts
`timescale 1ns/100ps
`default_nettype none
module ext_source
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic xtal_i,
    input wire logic slow_i,
    input wire logic [7:0] count_i,
    output logic ext_clk_o,
    output logic xtal_o,
    output logic busy_o
);
    logic [7:0] left = 8'h00;
    logic [3:0] ph = 4'h0;
    logic lvl = 1'h0;
    logic last;
    assign last = ph == (slow_i ? 4'hB : 4'h3);
    // Burst of rising edges; fast mode tests the synchroniser margin
    always @(posedge clk_i)
    begin
        if (go_i && left == 8'h00)
            left <= count_i;
        else if (left != 8'h00)
        begin
            ph <= last ? 4'h0 : ph + 4'h1;
            lvl <= last ? !lvl : lvl;
            left <= (last && lvl) ? left - 8'h01 : left;
        end
    end
    // Unselected pin stays low
    assign ext_clk_o = lvl && !xtal_i;
    assign xtal_o = lvl && xtal_i;
    assign busy_o = left != 8'h00;
endmodule
`default_nettype wire

// ### tb/wide_event_counter_tb.sv
// Purpose: Self-checking bench for the wide event counter
// Assumes: APB slave answers within a few cycles
// Notes: Count windows allow one tick of phase slack
`timescale 1ns/100ps
`default_nettype none
module wide_event_counter_tb;
    localparam logic [31:0] FLG = 32'h30;
    localparam logic [31:0] LO = 32'h38;
    localparam logic [31:0] HI = 32'h3C;
    localparam logic [31:0] CTL = 32'h40;
    logic clk = 1'h0, rst_b = 1'h0, por = 1'h1, slp = 1'h0, psel = 1'h0;
    logic pen = 1'h0, pwr = 1'h0, go = 1'h0, use_x = 1'h0, slow = 1'h0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, amp, oe_b, tbv, wake, irq, ext_clk, xtal, busy;
    logic serr;
    logic [7:0] n = 8'h0;
    logic [15:0] cv;
    int fails = 0, total_checks = 0, cyc = 0;
    // Core clock, 25 ns
    initial
    begin
        forever #12.5 clk = !clk;
    end
    wide_event_counter wide_event_counter_inst
    (
        .CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'h1), .POR_BOR_I(por),
        .SLEEP_I(slp), .EXT_CLK_I(ext_clk), .CRYSTAL_INPUT_PIN_I(xtal),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CRYSTAL_AMP_OUTPUT_PIN_O(amp),
        .CRYSTAL_AMP_OE_B_O(oe_b), .TIMEBASE_VALID_O(tbv), .WAKE_O(wake),
        .IRQ_O(irq)
    );
    ext_source ext_source_inst
    (
        .clk_i(clk), .go_i(go), .xtal_i(use_x), .slow_i(slow), .count_i(n),
        .ext_clk_o(ext_clk), .xtal_o(xtal), .busy_o(busy)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; ready, read data and error are all taken at the
    // rising edge that samples ready high; only the hang guard ends a wait
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [15:0] e);
        xfer(1'h0, a, 32'h0);
        chk({8'h0, rdat[7:0]}, e);
    endtask
    // High, low, high again; a changed high byte means a rollover
    task automatic cnt(output logic [15:0] v);
        logic [7:0] h;
        xfer(1'h0, HI, 32'h0);
        h = rdat[7:0];
        xfer(1'h0, LO, 32'h0);
        v[7:0] = rdat[7:0];
        xfer(1'h0, HI, 32'h0);
        v[15:8] = rdat[7:0];
        if (v[15:8] !== h)
        begin
            xfer(1'h0, HI, 32'h0);
            v[15:8] = rdat[7:0];
            xfer(1'h0, LO, 32'h0);
            v[7:0] = rdat[7:0];
        end
    endtask
    // Zero the count while stopped, then load the control value
    task automatic start(input logic [31:0] c);
        xfer(1'h1, CTL, 32'h0);
        xfer(1'h1, LO, 32'h0);
        xfer(1'h1, HI, 32'h0);
        xfer(1'h1, CTL, c);
    endtask
    task automatic pulse(input logic [7:0] c, input logic x, input logic s);
        n <= c;
        use_x <= x;
        slow <= s;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        do
            @(posedge clk);
        while (busy !== 1'h0);
        repeat (8) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard, well beyond the few thousand cycles needed
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        por <= 1'h0;
        @(posedge clk);
        rchk(CTL, 16'h0);
        rchk(FLG, 16'h0);
        rchk(32'h230, 16'h0);
        rchk(32'h44, 16'h0);
        xfer(1'h0, 32'h41, 32'h0);
        chk({15'h0, serr}, 16'h1);
        xfer(1'h1, CTL, 32'hC0);
        rchk(CTL, 16'h0);
        for (int p = 0; p < 4; p++)
        begin
            start(32'h1 | (p << 4));
            repeat (254) @(posedge clk);
            xfer(1'h1, CTL, 32'h0);
            cnt(cv);
            chk({15'h0, cv >= 16'((64 >> p) - 1) && cv <= 16'((64 >> p) + 1)},
                16'h1);
        end
        xfer(1'h1, LO, 32'hFC);
        xfer(1'h1, HI, 32'hFF);
        xfer(1'h1, 32'h230, 32'h1);
        xfer(1'h1, CTL, 32'h1);
        @(posedge clk);
        chk({15'h0, tbv}, 16'h1);
        repeat (40) @(posedge clk);
        rchk(FLG, 16'h1);
        chk({15'h0, irq}, 16'h1);
        xfer(1'h1, FLG, 32'h0);
        rchk(FLG, 16'h0);
        chk({15'h0, irq}, 16'h0);
        xfer(1'h1, 32'h54, 32'h10);
        xfer(1'h1, 32'h58, 32'h0);
        xfer(1'h1, 32'h5C, 32'hB);
        start(32'h1);
        repeat (300) @(posedge clk);
        xfer(1'h1, CTL, 32'h0);
        cnt(cv);
        chk({15'h0, cv <= 16'h10}, 16'h1);
        rchk(FLG, 16'h0);
        // Compare at the top count: the clear must not raise the flag
        xfer(1'h1, 32'h54, 32'hFF);
        xfer(1'h1, 32'h58, 32'hFF);
        xfer(1'h1, LO, 32'hF0);
        xfer(1'h1, HI, 32'hFF);
        xfer(1'h1, CTL, 32'h1);
        repeat (100) @(posedge clk);
        xfer(1'h1, CTL, 32'h0);
        rchk(FLG, 16'h0);
        cnt(cv);
        chk({15'h0, cv <= 16'h20}, 16'h1);
        xfer(1'h1, 32'h5C, 32'h0);
        xfer(1'h1, LO, 32'h34);
        xfer(1'h1, HI, 32'h12);
        xfer(1'h1, CTL, 32'h38);
        rst_b <= 1'h0;
        @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        rchk(CTL, 16'h38);
        por <= 1'h1;
        @(posedge clk);
        por <= 1'h0;
        @(posedge clk);
        rchk(CTL, 16'h0);
        cnt(cv);
        chk(cv, 16'h1234);
        start(32'h3);
        pulse(8'h5, 1'h0, 1'h1);
        slp <= 1'h1;
        pulse(8'h4, 1'h0, 1'h0);
        slp <= 1'h0;
        cnt(cv);
        chk(cv, 16'h5);
        xfer(1'h1, CTL, 32'h0);
        xfer(1'h1, LO, 32'hFE);
        xfer(1'h1, HI, 32'hFF);
        xfer(1'h1, 32'h230, 32'h1);
        xfer(1'h1, CTL, 32'h7);
        @(posedge clk);
        chk({15'h0, tbv}, 16'h0);
        slp <= 1'h1;
        pulse(8'h3, 1'h0, 1'h0);
        chk({15'h0, wake}, 16'h1);
        slp <= 1'h0;
        cnt(cv);
        chk(cv, 16'h1);
        start(32'hB);
        @(posedge clk);
        chk({15'h0, oe_b}, 16'h0);
        repeat (20) @(posedge clk);
        pulse(8'h6, 1'h1, 1'h1);
        cnt(cv);
        chk(cv, 16'h6);
        tally_and_finish();
    end
endmodule
`default_nettype wire
